// *** rtl/exarb_consts.svh ***
`ifndef EXARB_CONSTS_SVH
`define EXARB_CONSTS_SVH

// Register offsets on the plain register port
`define EXARB_OFS_PEND_LOW 8'h00
`define EXARB_OFS_PEND_MID 8'h01
`define EXARB_OFS_PEND_HIGH 8'h02
`define EXARB_OFS_ENABLE_LOW 8'h03
`define EXARB_OFS_ENABLE_MID 8'h04
`define EXARB_OFS_ENABLE_HIGH 8'h05
`define EXARB_OFS_STATE 8'h06

// Source count and vector slots
`define EXARB_NUM_SRC 21
`define EXARB_VEC_RESERVED 16'hFFD0
`define EXARB_VEC_LOWEST 16'hFFD2
`define EXARB_VEC_HIGHEST 16'hFFFA
`define EXARB_VEC_SWI 16'hFFFC
`define EXARB_VEC_RESET 16'hFFFE

// Reset values
`define EXARB_ENABLE_RST 21'h00_0000
`define EXARB_PC_RST 16'h0000

`endif

// *** rtl/exarb_pkg.sv ***
package exarb_pkg;

    // CPU side event strobes
    typedef struct packed {
        logic insn_done;
        logic swi_exec;
        logic rti_exec;
    } exarb_cpu_evt_t;

    // Stacking controls sent to the core
    typedef struct packed {
        logic push_frame;
        logic pop_frame;
        logic push_index_high;
        logic set_mask;
        logic discard_prefetch;
    } exarb_stack_ctl_t;

    // Controller states
    typedef enum logic [1:0] {
        EXARB_IDLE,
        EXARB_SERVICE
    } exarb_state_t;

endpackage : exarb_pkg

// *** rtl/exarb_prio_enc.sv ***
`timescale 1ns/10ps
`include "exarb_consts.svh"

// Fixed-priority encoder: flag 1 is highest, flag 21 lowest
module exarb_prio_enc (
    // Candidate flags, bit i is flag i+1
    input wire logic [20:0] req,
    // Result
    output logic hit,
    output logic [4:0] idx
);

    // Scan from lowest priority so the highest one wins last
    always_comb begin
        hit = 1'b0;
        idx = 5'h00;
        for (int i = `EXARB_NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                hit = 1'b1;
                idx = 5'(i);
            end
        end
    end

endmodule : exarb_prio_enc

// *** rtl/exarb_arbiter.sv ***
`timescale 1ns/10ps
`include "exarb_consts.svh"

module exarb_arbiter
    import exarb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Peripheral request lines, bit i is flag i+1
    input wire logic [20:0] irq_req,
    // CPU core side
    input wire exarb_cpu_evt_t cpu_evt,
    input wire logic mask_bit,
    input wire logic [15:0] cpu_pc,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Exception outputs to the core
    output logic take_exc,
    output logic [15:0] vector_addr,
    output logic [15:0] stacked_pc,
    output exarb_stack_ctl_t stack_ctl,
    output logic mask_set_req
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [20:0] sync1_ff;
    logic [20:0] sync2_ff;
    logic [20:0] sync3_ff;
    logic [20:0] pend_ff;
    logic [20:0] enable_ff;
    logic latched_ff;
    logic [4:0] latched_idx_ff;
    exarb_state_t state_ff;
    logic [7:0] reg_rdata_ff;
    logic take_exc_ff;
    logic [15:0] vector_ff;
    logic [15:0] stacked_pc_ff;
    exarb_stack_ctl_t stack_ctl_ff;
    logic mask_set_ff;

    logic [20:0] nxt_pend;
    logic [20:0] nxt_enable;
    logic nxt_latched;
    logic [4:0] nxt_latched_idx;
    exarb_state_t nxt_state;
    logic [7:0] nxt_reg_rdata;
    logic nxt_take_exc;
    logic [15:0] nxt_vector;
    logic [15:0] nxt_stacked_pc;
    exarb_stack_ctl_t nxt_stack_ctl;
    logic nxt_mask_set;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Vector slot of flag n (1..21): two bytes per slot below FFFC
    function automatic logic [15:0] slot_vector(input logic [4:0] idx0);
        logic [15:0] off;
        off = {10'h000, idx0, 1'b0};
        slot_vector = `EXARB_VEC_HIGHEST - off;
    endfunction : slot_vector

    // Pack a window of flags into a status byte
    function automatic logic [7:0] pick8(input logic [20:0] v, input logic [4:0] lo);
        logic [20:0] s;
        s = v >> lo;
        pick8 = s[7:0];
    endfunction : pick8

    // ------------------------------------------------------------
    // Request synchronisers
    // ------------------------------------------------------------
    // Pins come from other clock domains; three stages, change on agreement
    always_ff @(posedge clk) begin
        sync1_ff <= irq_req;
        sync2_ff <= sync1_ff;
        sync3_ff <= sync2_ff;
    end

    // Live flag follows the request only once stages two and three agree
    wire [20:0] agree = ~(sync2_ff ^ sync3_ff);
    assign nxt_pend = (agree & sync3_ff) | (~agree & pend_ff);

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    wire [20:0] eligible = pend_ff & enable_ff;
    wire arb_hit;
    wire [4:0] arb_idx;

    exarb_prio_enc u_prio (
        .req(eligible),
        .hit(arb_hit),
        .idx(arb_idx)
    );

    // Events from the core
    wire insn_done = cpu_evt.insn_done;
    wire swi_exec = cpu_evt.swi_exec;
    wire rti_exec = cpu_evt.rti_exec;

    // Latch only once mask is clear; a latched winner is held until serviced or until it is no longer eligible while mask is clear
    wire can_latch = ~latched_ff & arb_hit & ~mask_bit;
    wire [4:0] use_idx = latched_ff ? latched_idx_ff : arb_idx;
    wire have_req = latched_ff | can_latch;

    // Hardware entry only at instruction boundary
    wire hw_entry = insn_done & have_req & ~mask_bit & ~swi_exec;
    // Return with a request still pending chains straight back in; the core's
    // mask is still set while the return executes, so it is not consulted here
    wire chain_entry = rti_exec & (latched_ff | arb_hit);

    // Latch state and FSM next values
    always_comb begin
        nxt_latched = latched_ff;
        nxt_latched_idx = latched_idx_ff;
        nxt_state = state_ff;
        if (can_latch) begin
            nxt_latched = 1'b1;
            nxt_latched_idx = arb_idx;
        end
        // Mask clear with the latched flag no longer eligible releases the latch
        if (latched_ff && mask_bit == 1'b0 && !eligible[latched_idx_ff]) begin
            nxt_latched = 1'b0;
        end
        if (swi_exec) begin
            nxt_state = EXARB_SERVICE;
        end else if (hw_entry || chain_entry) begin
            nxt_state = EXARB_SERVICE;
            nxt_latched = 1'b0;
        end else if (rti_exec) begin
            nxt_state = EXARB_IDLE;
        end
    end

    // Exception outputs: trap beats maskable sources
    always_comb begin
        nxt_take_exc = 1'b0;
        nxt_vector = vector_ff;
        nxt_stacked_pc = stacked_pc_ff;
        nxt_stack_ctl = '0;
        nxt_mask_set = 1'b0;
        if (swi_exec) begin
            nxt_take_exc = 1'b1;
            nxt_vector = `EXARB_VEC_SWI;
            nxt_stacked_pc = cpu_pc;
            nxt_stack_ctl.push_frame = 1'b1;
            nxt_stack_ctl.set_mask = 1'b1;
            nxt_mask_set = 1'b1;
        end else if (hw_entry || chain_entry) begin
            nxt_take_exc = 1'b1;
            nxt_vector = slot_vector(use_idx);
            nxt_stacked_pc = cpu_pc - 16'h0001;
            nxt_stack_ctl.push_frame = ~chain_entry;
            nxt_stack_ctl.set_mask = 1'b1;
            nxt_stack_ctl.discard_prefetch = chain_entry;
            nxt_mask_set = 1'b1;
        end else if (rti_exec) begin
            nxt_stack_ctl.pop_frame = 1'b1;
        end
        nxt_stack_ctl.push_index_high = 1'b0;
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // Status bytes
    wire [7:0] stat_low = {pend_ff[5:0], 2'b00};
    wire [7:0] stat_mid = pick8(pend_ff, 5'd6);
    wire [7:0] stat_high = {1'b0, pend_ff[20:14]};
    wire [7:0] st_byte = {6'h00, latched_ff, state_ff == EXARB_SERVICE};

    // Write decode: status offsets fall through, so writes do nothing
    always_comb begin
        nxt_enable = enable_ff;
        if (reg_wr && reg_addr == `EXARB_OFS_ENABLE_LOW) begin
            nxt_enable[5:0] = reg_wdata[7:2];
        end else if (reg_wr && reg_addr == `EXARB_OFS_ENABLE_MID) begin
            nxt_enable[13:6] = reg_wdata;
        end else if (reg_wr && reg_addr == `EXARB_OFS_ENABLE_HIGH) begin
            nxt_enable[20:14] = reg_wdata[6:0];
        end
    end

    // Read decode; unmapped reads return zero
    always_comb begin
        nxt_reg_rdata = 8'h00;
        if (!reg_rd) begin
            nxt_reg_rdata = 8'h00;
        end else if (reg_addr == `EXARB_OFS_PEND_LOW) begin
            nxt_reg_rdata = stat_low;
        end else if (reg_addr == `EXARB_OFS_PEND_MID) begin
            nxt_reg_rdata = stat_mid;
        end else if (reg_addr == `EXARB_OFS_PEND_HIGH) begin
            nxt_reg_rdata = stat_high;
        end else if (reg_addr == `EXARB_OFS_ENABLE_LOW) begin
            nxt_reg_rdata = {enable_ff[5:0], 2'b00};
        end else if (reg_addr == `EXARB_OFS_ENABLE_MID) begin
            nxt_reg_rdata = enable_ff[13:6];
        end else if (reg_addr == `EXARB_OFS_ENABLE_HIGH) begin
            nxt_reg_rdata = {1'b0, enable_ff[20:14]};
        end else if (reg_addr == `EXARB_OFS_STATE) begin
            nxt_reg_rdata = st_byte;
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    // Reset sits above every arbitration path and forces the reset vector
    always_ff @(posedge clk) begin
        if (srst) begin
            pend_ff <= 21'h00_0000;
            enable_ff <= `EXARB_ENABLE_RST;
            latched_ff <= 1'b0;
            latched_idx_ff <= 5'h00;
            state_ff <= EXARB_IDLE;
            reg_rdata_ff <= 8'h00;
            take_exc_ff <= 1'b0;
            vector_ff <= `EXARB_VEC_RESET;
            stacked_pc_ff <= `EXARB_PC_RST;
            stack_ctl_ff <= '0;
            mask_set_ff <= 1'b0;
        end else begin
            pend_ff <= nxt_pend;
            enable_ff <= nxt_enable;
            latched_ff <= nxt_latched;
            latched_idx_ff <= nxt_latched_idx;
            state_ff <= nxt_state;
            reg_rdata_ff <= nxt_reg_rdata;
            take_exc_ff <= nxt_take_exc;
            vector_ff <= nxt_vector;
            stacked_pc_ff <= nxt_stacked_pc;
            stack_ctl_ff <= nxt_stack_ctl;
            mask_set_ff <= nxt_mask_set;
        end
    end

    // Outputs straight from flops
    assign reg_rdata = reg_rdata_ff;
    assign take_exc = take_exc_ff;
    assign vector_addr = vector_ff;
    assign stacked_pc = stacked_pc_ff;
    assign stack_ctl = stack_ctl_ff;
    assign mask_set_req = mask_set_ff;

endmodule : exarb_arbiter

// *** dv/exarb_properties.sv ***
`timescale 1ns/10ps
`include "exarb_consts.svh"
module exarb_properties
    import exarb_pkg::*;
(
    // Watched ports
    input wire logic clk,
    input wire logic srst,
    input wire exarb_cpu_evt_t cpu_evt,
    input wire logic mask_bit,
    input wire logic [15:0] cpu_pc,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic take_exc,
    input wire logic [15:0] vector_addr,
    input wire logic [15:0] stacked_pc,
    input wire exarb_stack_ctl_t stack_ctl,
    input wire logic mask_set_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // --------------------------------
    // Entry sequences
    // --------------------------------
    sequence trap_s;
        cpu_evt.swi_exec ##1 take_exc;
    endsequence
    sequence hw_s;
        cpu_evt.insn_done && !cpu_evt.swi_exec && !cpu_evt.rti_exec ##1 take_exc;
    endsequence
    sequence chain_s;
        cpu_evt.rti_exec && !cpu_evt.swi_exec ##1 take_exc;
    endsequence
    trap_entry_a: assert property (cpu_evt.swi_exec |=> take_exc)
        else $error("trap gave no entry");
    trap_frame_a: assert property (trap_s |-> vector_addr == `EXARB_VEC_SWI
        && stacked_pc == $past(cpu_pc)) else $error("trap vector or pc wrong");
    hw_pc_a: assert property (hw_s |-> stacked_pc == $past(cpu_pc) - 16'h0001)
        else $error("hardware entry pc wrong");
    masked_hw_a: assert property (cpu_evt.insn_done && mask_bit && cpu_evt[1:0] == 2'b00
        |=> !take_exc) else $error("entry while masked");
    entry_cause_a: assert property (take_exc |-> $past(cpu_evt) != 3'b000)
        else $error("entry without boundary");
    entry_mask_a: assert property (take_exc |-> mask_set_req && stack_ctl.set_mask)
        else $error("entry did not mask");
    no_index_a: assert property (!stack_ctl.push_index_high)
        else $error("index pushed");
    vec_slot_a: assert property (take_exc |-> vector_addr >= `EXARB_VEC_LOWEST
        && vector_addr <= `EXARB_VEC_SWI && !vector_addr[0]) else $error("bad vector");
    chain_drop_a: assert property (chain_s |-> stack_ctl.discard_prefetch
        && !stack_ctl.push_frame) else $error("chain kept prefetch");
    rti_pop_a: assert property (cpu_evt.rti_exec && !cpu_evt.swi_exec
        |=> stack_ctl.pop_frame != take_exc) else $error("return did not pop");
    low_bits_a: assert property (reg_rd && reg_addr == `EXARB_OFS_PEND_LOW
        |=> reg_rdata[1:0] == 2'b00) else $error("low status bits set");
endmodule : exarb_properties

bind exarb_arbiter exarb_properties chk_u (
    .clk(clk), .srst(srst), .cpu_evt(cpu_evt), .mask_bit(mask_bit),
    .cpu_pc(cpu_pc), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .take_exc(take_exc), .vector_addr(vector_addr), .stacked_pc(stacked_pc),
    .stack_ctl(stack_ctl), .mask_set_req(mask_set_req)
);

// *** dv/exarb_core_model.sv ***
`timescale 1ns/10ps
// Core stand-in: an instruction ends every fourth cycle, handlers are short
module exarb_core_model
    import exarb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Controls
    input wire logic hold_mask,
    input wire logic swi_go,
    input wire logic take_exc,
    input wire logic mask_set_req,
    // Core outputs
    output exarb_cpu_evt_t cpu_evt,
    output logic mask_bit,
    output logic [15:0] cpu_pc
);
    logic [3:0] isr_ff;
    logic mask_ff;
    logic [1:0] step_ff;
    // Bench can hold the mask to test refusal
    assign mask_bit = mask_ff | hold_mask;
    // Handler lasts eight cycles, then returns and unmasks
    always_ff @(posedge clk) begin
        if (srst) begin
            isr_ff <= 4'h0;
            mask_ff <= 1'b0;
            step_ff <= 2'h0;
            cpu_pc <= 16'h0100;
            cpu_evt <= '0;
        end else begin
            step_ff <= step_ff + 2'h1;
            cpu_evt.insn_done <= (step_ff == 2'h3);
            cpu_evt.swi_exec <= swi_go;
            cpu_evt.rti_exec <= (isr_ff == 4'h1);
            isr_ff <= take_exc ? 4'h8 : (isr_ff != 4'h0 ? isr_ff - 4'h1 : 4'h0);
            mask_ff <= mask_set_req | (mask_ff & !cpu_evt.rti_exec);
            cpu_pc <= cpu_pc + {14'h0000, step_ff == 2'h3, 1'b0};
        end
    end
endmodule : exarb_core_model

// *** dv/test_exception_interrupt_arbiter.sv ***
`timescale 1ns/10ps
`include "exarb_consts.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
    $display("FAIL %0t got %h exp %h", $time, (a), (e)); end end
module test_exception_interrupt_arbiter;
    import exarb_pkg::*;
    logic clk, srst, reg_wr, reg_rd, take_exc, mask_set_req, mask_bit, hold_mask, swi_go, got;
    logic [20:0] irq_req, r;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [15:0] vector_addr, stacked_pc, cpu_pc;
    exarb_cpu_evt_t cpu_evt;
    exarb_stack_ctl_t stack_ctl;
    int bad_count, samples_checked, cyc, i;
    exarb_arbiter dut_u (.clk(clk), .srst(srst), .irq_req(irq_req), .cpu_evt(cpu_evt),
        .mask_bit(mask_bit), .cpu_pc(cpu_pc), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .take_exc(take_exc),
        .vector_addr(vector_addr), .stacked_pc(stacked_pc), .stack_ctl(stack_ctl),
        .mask_set_req(mask_set_req));
    exarb_core_model core_u (.clk(clk), .srst(srst), .hold_mask(hold_mask), .swi_go(swi_go),
        .take_exc(take_exc), .mask_set_req(mask_set_req), .cpu_evt(cpu_evt),
        .mask_bit(mask_bit), .cpu_pc(cpu_pc));
    always #2.5 clk = ~clk;
    // Expected status byte k for request lines q
    function automatic logic [7:0] stat(input logic [20:0] q, input int k);
        return k == 0 ? {q[5:0], 2'b00} : k == 1 ? q[13:6] : {1'b0, q[20:14]};
    endfunction : stat
    // Flag 1 wins; each lower flag sits two bytes further down
    function automatic logic [15:0] vec(input logic [20:0] q);
        for (int n = 20; n >= 0; n--) begin
            if (q[n]) begin
                vec = `EXARB_VEC_HIGHEST - 16'(2 * n);
            end
        end
    endfunction : vec
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    // Bounded wait for an entry pulse
    task wexc(output logic g);
        g = 1'b0;
        for (int n = 0; n < 40 && !g; n++) begin
            @(posedge clk);
            #1 g = take_exc;
        end
    endtask : wexc
    task final_report;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    // Hang guard, well above the several hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            bad_count++;
            final_report;
        end
    end
    initial begin
        {clk, reg_wr, reg_rd, hold_mask, swi_go, irq_req, reg_addr, reg_wdata} = '0;
        srst = 1'b1;
        void'($urandom(51833));
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        #1 `CHK(vector_addr, `EXARB_VEC_RESET)
        // Enables still off, so status reads see raw lines only
        for (i = 0; i < 8; i++) begin
            r = i == 0 ? 21'h1F_FFFF : i == 1 ? 21'h00_0000 : 21'($urandom);
            @(posedge clk);
            irq_req <= r;
            repeat (6) @(posedge clk);
            wr(`EXARB_OFS_PEND_LOW, 8'hFF);
            rd(`EXARB_OFS_PEND_LOW, d);
            `CHK(d, stat(r, 0))
            rd(`EXARB_OFS_PEND_MID, d);
            `CHK(d, stat(r, 1))
            rd(`EXARB_OFS_PEND_HIGH, d);
            `CHK(d, stat(r, 2))
        end
        rd(8'h7F, d);
        `CHK(d, 8'h00)
        $display("test status done");
        wr(`EXARB_OFS_ENABLE_LOW, 8'hFC);
        wr(`EXARB_OFS_ENABLE_MID, 8'hFF);
        wr(`EXARB_OFS_ENABLE_HIGH, 8'h7F);
        for (i = 0; i < 12; i++) begin
            @(posedge clk);
            irq_req <= '0;
            repeat (30) @(posedge clk);
            r = i == 0 ? 21'h1F_FFFF : i == 1 ? 21'h10_0000 : 21'($urandom) | 21'h10_0000;
            irq_req <= r;
            wexc(got);
            `CHK(got, 1'b1)
            `CHK(vector_addr, vec(r))
        end
        // Request still up when the handler returns
        wexc(got);
        `CHK(got, 1'b1)
        `CHK(stack_ctl.discard_prefetch, 1'b1)
        $display("test priority done");
        @(posedge clk);
        irq_req <= '0;
        hold_mask <= 1'b1;
        repeat (30) @(posedge clk);
        irq_req <= 21'h00_0001;
        wexc(got);
        `CHK(got, 1'b0)
        @(posedge clk);
        swi_go <= 1'b1;
        @(posedge clk);
        swi_go <= 1'b0;
        wexc(got);
        `CHK(got, 1'b1)
        `CHK(vector_addr, `EXARB_VEC_SWI)
        $display("test mask done");
        final_report;
    end
endmodule : test_exception_interrupt_arbiter
